// file: src/ltp_pkg.sv
// Constants and state types for the test pattern generator.
// Assumes one pixel clock and a register write port at the printed addresses.
package ltp_pkg;
	localparam int CODE_W = 14;
	localparam logic [5:0] OFS_START_H = 6'h30;
	localparam logic [5:0] OFS_START_L = 6'h31;
	localparam logic [5:0] OFS_WIDTH_H = 6'h32;
	localparam logic [5:0] OFS_WIDTH_L = 6'h33;
	localparam logic [5:0] OFS_CONTROL = 6'h34;
	localparam logic [5:0] OFS_PITCH   = 6'h35;
	localparam logic [5:0] OFS_STEP    = 6'h36;
	localparam logic [5:0] OFS_DELAY   = 6'h37;
	localparam logic [5:0] OFS_VALUE_H = 6'h38;
	localparam logic [5:0] OFS_VALUE_L = 6'h39;
	localparam int CTL_TP_BIT   = 7;
	localparam int CTL_MODE_HI  = 6;
	localparam int CTL_MODE_LO  = 4;
	localparam int CTL_PRBS_BIT = 3;
	localparam int CTL_SEED_BIT = 2;
	localparam logic [7:0]  REG_RST   = 8'h00;
	localparam logic [13:0] LFSR_RST  = 14'h0001;
	localparam logic [16:0] PIX_MAX   = 17'h1ffff;
	typedef enum logic [2:0] {
		MODE_FIXED  = 3'h0,
		MODE_HGRAD  = 3'h1,
		MODE_VGRAD  = 3'h2,
		MODE_LATT   = 3'h3,
		MODE_STRIPE = 3'h4,
		MODE_LINK_S = 3'h5,
		MODE_LINK_F = 3'h6,
		MODE_NONE   = 3'h7
	} ltp_mode_t;
	localparam logic [1:0] SEL_BOTH = 2'h0;
	localparam logic [1:0] SEL_CH1  = 2'h1;
	localparam logic [1:0] SEL_CH2  = 2'h2;
	typedef struct packed {
		logic [4:0]  skip;
		logic [7:0]  v_cnt;
		logic [13:0] v_acc;
	} ltp_vstate_t;
	typedef struct packed {
		logic [7:0]  st_h;
		logic [7:0]  st_l;
		logic [7:0]  wd_h;
		logic [7:0]  wd_l;
		logic [7:0]  ctl;
		logic [7:0]  pitch;
		logic [7:0]  step;
		logic [3:0]  dly;
		logic [7:0]  val_h;
		logic [5:0]  val_l;
		logic [7:0]  rdata;
		logic [2:0]  sync;
		logic        lvl;
		logic [16:0] pix;
		logic [7:0]  h_cnt;
		logic [13:0] h_acc;
		logic        h_band;
		logic [13:0] lfsr;
		logic [13:0] out1;
		logic [13:0] out2;
	} ltp_state_t;
endpackage : ltp_pkg

// file: src/ltp_vtrack.sv
// Per-channel line tracker: vertical ramp and grid line state.
// Assumes line_edge is a one-cycle pulse on the pixel clock.
`timescale 1ns/1ps
module ltp_vtrack
	import ltp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clear,
	input  wire logic        line_edge,
	input  wire logic [3:0]  delay,
	input  wire logic [7:0]  pitch,
	input  wire logic [7:0]  step,
	input  wire logic [13:0] init,
	output logic      [13:0] v_acc,
	output logic             v_grid
);
	ltp_vstate_t r;
	ltp_vstate_t n;

	always_comb
	begin
		n = r;
		if (clear)
		begin
			n.skip  = 5'h00;
			n.v_cnt = 8'h00;
			n.v_acc = init;
		end
		else if (line_edge)
		begin
			// Frozen for delay+1 edges so channel 2 lags by whole lines
			if (r.skip <= {1'b0, delay})
				n.skip = r.skip + 5'h01;
			else if ({1'b0, r.v_cnt} + 9'h001 >= {1'b0, pitch})
			begin
				n.v_cnt = 8'h00;
				n.v_acc = r.v_acc + {6'h00, step};
			end
			else
				n.v_cnt = r.v_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end

	assign v_acc  = r.v_acc;
	assign v_grid = (r.v_cnt == 8'h00);
endmodule : ltp_vtrack

// file: src/ltp_gen.sv
// Test pattern generator replacing the converted sample stream of two channels.
// Assumes converted data on the pixel clock and an asynchronous line-start pin.
// Contract
// - 16-bit start count from line start
// - 16-bit width count of valid region
// - Control bit 7 selects pattern over data
// - Mode field picks fixed, gradients, lattice, stripe
// - Modes 101/110 link test, synced or free
// - Control bit 3 random pattern overrides bit 7
// - Bit 2 reloads seed each line start
// - Channel select: both, one or two
// - Pitch gives pixels per step or band
// - Pitch gives lines per step, grid period
// - Gradients rise by step value per step
// - Step value is lattice/stripe low code
// - Channel 2 lags by offset lines
// - Value upper bits form fixed/link code
// - Gradients start from pattern value
// - Value is lattice/stripe high code
// - Next register holds value low six bits
`timescale 1ns/1ps
module ltp_gen
	import ltp_pkg::*;
(
	input  wire logic         CORE_CLK,
	input  wire logic         NRST,
	input  wire logic         LINE_START_PULSE,
	input  wire logic [13:0]  CH1_IN,
	input  wire logic [13:0]  CH2_IN,
	input  wire logic         REG_WR,
	input  wire logic [5:0]   REG_ADDR,
	input  wire logic [7:0]   REG_WDATA,
	output logic      [7:0]   REG_RDATA,
	output logic      [13:0]  CH1_OUT,
	output logic      [13:0]  CH2_OUT
);
	import ltp_pkg::*;

	ltp_state_t  r;
	ltp_state_t  n;
	logic        tp_on;
	logic        prbs;
	ltp_mode_t   mode;
	logic [1:0]  sel;
	logic [13:0] value;
	logic [13:0] step14;
	logic [16:0] start17;
	logic [16:0] end17;
	logic        in_reg;
	logic        edge_det;
	logic        clear;
	logic        fb;
	logic [13:0] v_acc1;
	logic [13:0] v_acc2;
	logic        v_grid1;
	logic        v_grid2;

	assign tp_on   = r.ctl[CTL_TP_BIT];
	assign prbs    = r.ctl[CTL_PRBS_BIT];
	assign mode    = ltp_mode_t'(r.ctl[CTL_MODE_HI:CTL_MODE_LO]);
	assign sel     = r.ctl[1:0];
	assign value   = {r.val_h, r.val_l};
	assign step14  = {6'h00, r.step};
	assign start17 = {1'b0, r.st_h, r.st_l};
	assign end17   = start17 + {1'b0, r.wd_h, r.wd_l};
	assign in_reg  = (r.pix >= start17) && (r.pix < end17);
	// Edge counts only once the second and third stages agree
	assign edge_det = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.lvl;
	assign clear    = !(tp_on || prbs);
	assign fb       = r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[11] ^ r.lfsr[1];

	function automatic logic [13:0] ch_code(
		input logic        en,
		input logic [13:0] raw,
		input logic [13:0] vacc,
		input logic        vgrid
	);
		if (!en || clear)
			return raw;
		if (prbs)
			return in_reg ? r.lfsr : raw;
		// Free-running link code ignores the line timing entirely
		if (mode == MODE_LINK_F)
			return value;
		if (!in_reg)
			return raw;
		case (mode)
			MODE_FIXED:  return value;
			MODE_LINK_S: return value;
			MODE_HGRAD:  return r.h_acc;
			MODE_VGRAD:  return vacc;
			MODE_LATT:   return (r.h_cnt == 8'h00 || vgrid) ? value : step14;
			MODE_STRIPE: return r.h_band ? step14 : value;
			default:     return raw;
		endcase
	endfunction : ch_code

	function automatic logic [7:0] rd_mux(input logic [5:0] a);
		case (a)
			OFS_START_H: return r.st_h;
			OFS_START_L: return r.st_l;
			OFS_WIDTH_H: return r.wd_h;
			OFS_WIDTH_L: return r.wd_l;
			OFS_CONTROL: return r.ctl;
			OFS_PITCH:   return r.pitch;
			OFS_STEP:    return r.step;
			OFS_DELAY:   return {4'h0, r.dly};
			OFS_VALUE_H: return r.val_h;
			OFS_VALUE_L: return {2'h0, r.val_l};
			default:     return 8'h00;
		endcase
	endfunction : rd_mux

	always_comb
	begin
		n = r;
		n.sync = {r.sync[1:0], LINE_START_PULSE};
		if (r.sync[1] == r.sync[2])
			n.lvl = r.sync[2];
		if (REG_WR)
		begin
			case (REG_ADDR)
				OFS_START_H: n.st_h  = REG_WDATA;
				OFS_START_L: n.st_l  = REG_WDATA;
				OFS_WIDTH_H: n.wd_h  = REG_WDATA;
				OFS_WIDTH_L: n.wd_l  = REG_WDATA;
				OFS_CONTROL: n.ctl   = REG_WDATA;
				OFS_PITCH:   n.pitch = REG_WDATA;
				OFS_STEP:    n.step  = REG_WDATA;
				OFS_DELAY:   n.dly   = REG_WDATA[3:0];
				OFS_VALUE_H: n.val_h = REG_WDATA;
				OFS_VALUE_L: n.val_l = REG_WDATA[5:0];
				default:     n.ctl   = r.ctl;
			endcase
		end
		n.rdata = rd_mux(REG_ADDR);
		// Saturating count keeps the region shut until the next line start
		if (edge_det)
			n.pix = 17'h00000;
		else if (r.pix != PIX_MAX)
			n.pix = r.pix + 17'h00001;
		if (edge_det)
		begin
			n.h_cnt  = 8'h00;
			n.h_acc  = value;
			n.h_band = 1'b0;
		end
		else if (in_reg)
		begin
			if ({1'b0, r.h_cnt} + 9'h001 >= {1'b0, r.pitch})
			begin
				n.h_cnt  = 8'h00;
				n.h_acc  = r.h_acc + step14;
				n.h_band = !r.h_band;
			end
			else
				n.h_cnt = r.h_cnt + 8'h01;
		end
		if (edge_det && r.ctl[CTL_SEED_BIT])
			n.lfsr = value;
		else
			n.lfsr = {r.lfsr[12:0], fb};
		n.out1 = ch_code(sel == SEL_BOTH || sel == SEL_CH1, CH1_IN, v_acc1, v_grid1);
		n.out2 = ch_code(sel == SEL_BOTH || sel == SEL_CH2, CH2_IN, v_acc2, v_grid2);
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			r      <= '0;
			r.lfsr <= LFSR_RST;
			r.pix  <= PIX_MAX;
		end
		else
			r <= n;
	end

	ltp_vtrack u_v1 (
		.clk       (CORE_CLK),
		.nrst      (NRST),
		.clear     (clear),
		.line_edge (edge_det),
		.delay     (4'h0),
		.pitch     (r.pitch),
		.step      (r.step),
		.init      (value),
		.v_acc     (v_acc1),
		.v_grid    (v_grid1)
	);

	ltp_vtrack u_v2 (
		.clk       (CORE_CLK),
		.nrst      (NRST),
		.clear     (clear),
		.line_edge (edge_det),
		.delay     (r.dly),
		.pitch     (r.pitch),
		.step      (r.step),
		.init      (value),
		.v_acc     (v_acc2),
		.v_grid    (v_grid2)
	);

	assign REG_RDATA = r.rdata;
	assign CH1_OUT   = r.out1;
	assign CH2_OUT   = r.out2;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	property p_start;
		$rose(in_reg) |-> r.pix == start17;
	endproperty
	a_start: assert property (p_start) else $error("region opened off start");

	property p_width;
		$fell(in_reg) && !$past(edge_det) |-> r.pix == $past(end17);
	endproperty
	a_width: assert property (p_width) else $error("region width wrong");

	property p_normal;
		clear |=> CH1_OUT == $past(CH1_IN) && CH2_OUT == $past(CH2_IN);
	endproperty
	a_normal: assert property (p_normal) else $error("data not passed");

	property p_fixed;
		tp_on && !prbs && mode == MODE_FIXED && in_reg && sel == SEL_BOTH
			|=> CH1_OUT == $past(value) && CH2_OUT == $past(value);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed code wrong");

	property p_free;
		tp_on && !prbs && mode == MODE_LINK_F && sel == SEL_BOTH
			|=> CH1_OUT == $past(value);
	endproperty
	a_free: assert property (p_free) else $error("free link code wrong");

	property p_prbs;
		prbs && in_reg && sel != SEL_CH2 |=> CH1_OUT == $past(r.lfsr);
	endproperty
	a_prbs: assert property (p_prbs) else $error("random code wrong");

	property p_seed;
		edge_det && r.ctl[CTL_SEED_BIT] |=> r.lfsr == $past(value) ##1 r.lfsr != $past(r.lfsr);
	endproperty
	a_seed: assert property (p_seed) else $error("seed not loaded");

	property p_sel;
		sel == SEL_CH1 |=> CH2_OUT == $past(CH2_IN);
	endproperty
	a_sel: assert property (p_sel) else $error("channel 2 not raw");

	property p_ramp;
		$rose(in_reg) && $stable(value) |-> r.h_acc == value;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp start wrong");

	property p_outside;
		!in_reg && mode != MODE_LINK_F |=> CH1_OUT == $past(CH1_IN);
	endproperty
	a_outside: assert property (p_outside) else $error("pattern outside region");
endmodule : ltp_gen

// file: verification/ltp_host_model.sv
// Host-side model: raises the line-start pin on request.
// Assumes the generator's pixel clock; pin held four cycles so the pin filter sees it.
`timescale 1ns/1ps
module ltp_host_model
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic send_line,
	output logic      line_start_pulse
);
	logic [1:0] hold_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hold_q <= 2'h0;
			line_start_pulse <= 1'b0;
		end
		else
		begin
			hold_q <= send_line ? 2'h3 : hold_q - {1'b0, hold_q != 2'h0};
			line_start_pulse <= send_line | (hold_q != 2'h0);
		end
	end
endmodule : ltp_host_model

// file: verification/ltp_gen_tb_top.sv
// Self-checking bench for the test pattern generator.
// Assumes the host model drives the line pin; data inputs count every cycle.
`timescale 1ns/1ps
module ltp_gen_tb_top;
	import ltp_pkg::*;
	logic        clk, nrst, go, pin, wr;
	logic [5:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [13:0] in1, in2, out1, out2, val;
	logic [7:0]  pitch, step;
	logic [13:0] g1 [0:39], g2 [0:39], q1 [0:39], q2 [0:39];
	int          n_fail, n_checks;
	ltp_host_model u_ltp_host_model (.clk(clk), .nrst(nrst), .send_line(go),
		.line_start_pulse(pin));
	ltp_gen u_ltp_gen (.CORE_CLK(clk), .NRST(nrst), .LINE_START_PULSE(pin), .CH1_IN(in1),
		.CH2_IN(in2), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.CH1_OUT(out1), .CH2_OUT(out2));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Counting data makes every pass-through cycle distinguishable
	always @(posedge clk)
	begin
		in1 <= in1 + 14'h1;
		in2 <= (in1 + 14'h1) ^ 14'h2aaa;
	end
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk_code(input logic [13:0] got, input logic [13:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_code
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1;
		chk_reg(rdata, exp);
	endtask : rd_reg
	task automatic cfg(input logic [7:0] ctl, input logic [15:0] s, input logic [15:0] w);
		wr_reg(OFS_START_H, s[15:8]);
		wr_reg(OFS_START_L, s[7:0]);
		wr_reg(OFS_WIDTH_H, w[15:8]);
		wr_reg(OFS_WIDTH_L, w[7:0]);
		wr_reg(OFS_VALUE_H, val[13:6]);
		wr_reg(OFS_VALUE_L, {2'h0, val[5:0]});
		wr_reg(OFS_PITCH, pitch);
		wr_reg(OFS_STEP, step);
		wr_reg(OFS_CONTROL, ctl);
	endtask : cfg
	// Index n holds the outputs after the (n+1)th edge past the pin rise
	task automatic scan();
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge clk);
			#1;
			g1[n] = out1;
			g2[n] = out2;
			q1[n] = in1 - 14'h1;
			q2[n] = (in1 - 14'h1) ^ 14'h2aaa;
		end
	endtask : scan
	function automatic logic [13:0] pat(input int md, input int i);
		if (md == 1)
			return val + 14'(step) * 14'(i / pitch);
		if (md == 4)
			return ((i / pitch) % 2) ? {6'h0, step} : val;
		return val;
	endfunction : pat
	function automatic logic [13:0] lfsr_nx(input logic [13:0] l);
		return {l[12:0], l[13] ^ l[12] ^ l[11] ^ l[1]};
	endfunction : lfsr_nx
	task automatic line(input int md, input int s, input int w, input bit e1, input bit e2);
		logic inr;
		scan();
		for (int n = 0; n < 40; n++)
		begin
			inr = (n >= 4 + s) && (n < 4 + s + w);
			chk_code(g1[n], (inr && e1) ? pat(md, n - 4 - s) : q1[n]);
			chk_code(g2[n], (inr && e2) ? pat(md, n - 4 - s) : q2[n]);
		end
	endtask : line
	task automatic t_regs();
		for (int a = 'h30; a <= 'h39; a++)
			rd_reg(6'(a), REG_RST);
		wr_reg(OFS_DELAY, 8'hff);
		rd_reg(OFS_DELAY, 8'h0f);
		wr_reg(OFS_VALUE_L, 8'hff);
		rd_reg(OFS_VALUE_L, 8'h3f);
		wr_reg(OFS_START_H, 8'ha5);
		rd_reg(OFS_START_H, 8'ha5);
		wr_reg(6'h3a, 8'h5a);
		rd_reg(6'h3a, 8'h00);
		wr_reg(OFS_DELAY, 8'h00);
	endtask : t_regs
	task automatic t_modes();
		val = 14'h2d5b;
		pitch = 8'h2;
		step = 8'h3;
		cfg(8'h00, 16'h3, 16'h5);
		line(0, 3, 5, 0, 0);
		cfg(8'h80, 16'h3, 16'h5);
		line(0, 3, 5, 1, 1);
		cfg(8'h80, 16'h3, 16'h0);
		line(0, 3, 0, 1, 1);
		cfg(8'h81, 16'h3, 16'h5);
		line(0, 3, 5, 1, 0);
		cfg(8'h82, 16'h3, 16'h5);
		line(0, 3, 5, 0, 1);
		cfg(8'hd0, 16'h2, 16'h6);
		line(5, 2, 6, 1, 1);
		cfg(8'hf0, 16'h2, 16'h6);
		line(7, 2, 0, 1, 1);
		cfg(8'h90, 16'h1, 16'h9);
		line(1, 1, 9, 1, 1);
		pitch = 8'h3;
		cfg(8'hc0, 16'h2, 16'ha);
		line(4, 2, 10, 1, 1);
		cfg(8'he0, 16'h2, 16'h1);
		line(6, -4, 44, 1, 1);
	endtask : t_modes
	task automatic t_prbs();
		logic [13:0] first;
		cfg(8'h8c, 16'h2, 16'ha);
		scan();
		first = g1[6];
		for (int n = 6; n < 15; n++)
			chk_code(g1[n + 1], lfsr_nx(g1[n]));
		scan();
		chk_code(g1[6], first);
		chk_code(g2[7], lfsr_nx(g2[6]));
	endtask : t_prbs
	// Channel 2 is one line behind; both trackers freeze on the first edge after a clear
	task automatic t_vert();
		int e;
		val = 14'h0100;
		step = 8'h5;
		pitch = 8'h2;
		wr_reg(OFS_CONTROL, 8'h00);
		wr_reg(OFS_DELAY, 8'h01);
		cfg(8'ha0, 16'h2, 16'h4);
		for (int l = 0; l < 5; l++)
		begin
			scan();
			e = (l > 0) ? l - 1 : 0;
			for (int n = 0; n < 40; n++)
			begin
				chk_code(g1[n], (n >= 6 && n < 10) ? val + 14'(step) * 14'(l / 2) : q1[n]);
				chk_code(g2[n], (n >= 6 && n < 10) ? val + 14'(step) * 14'(e / 2) : q2[n]);
			end
		end
		wr_reg(OFS_CONTROL, 8'h00);
		cfg(8'hb0, 16'h2, 16'h4);
		for (int l = 0; l < 2; l++)
		begin
			scan();
			for (int n = 6; n < 10; n++)
			begin
				chk_code(g1[n], (l == 0 || n % 2 == 0) ? val : {6'h0, step});
				chk_code(g2[n], val);
			end
		end
	endtask : t_vert
	initial
	begin
		nrst = 1'b0;
		go = 1'b0;
		wr = 1'b0;
		addr = 6'h0;
		wdata = 8'h0;
		in1 = 14'h0;
		in2 = 14'h2aaa;
		n_fail = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_modes();
		t_prbs();
		t_vert();
		give_verdict();
	end
	initial
	begin
		#(100 * 20000);
		n_fail++;
		give_verdict();
	end
endmodule : ltp_gen_tb_top
